//--- rtl/bvc_pkg.sv
// Constants and carrier types for the converter control register bank
// What this block does
// - Low-select register: gate bit 7, code 6:0
// - Low select: enabled only if pin and gate
// - Gate zero disables despite enable pin high
// - Low select: code and low range drive target
// - Discharge bit 4 connects switch node at off
// - Low select uses forced-PWM bit 7
// - High select uses high register and range
`default_nettype none

package bvc_pkg;

	// Register offsets
	localparam logic [7:0] ADDR_VOLTAGE_SET_SELECT_PIN_HIGH  = 8'h10;
	localparam logic [7:0] ADDR_VOLTAGE_SET_SELECT_PIN_LOW   = 8'h11;
	localparam logic [7:0] ADDR_DISCHARGE  = 8'h12;
	localparam logic [7:0] ADDR_MODE       = 8'h14;
	localparam logic [7:0] ADDR_RANGE_HIGH = 8'h1C;
	localparam logic [7:0] ADDR_RANGE_LOW  = 8'h1D;

	// Field positions
	localparam int ENABLE_GATE_BIT = 7;
	localparam int CODE_MSB        = 6;
	localparam int DISCHARGE_BIT   = 4;
	localparam int PWM_LOW_BIT     = 7;
	localparam int PWM_HIGH_BIT    = 6;
	localparam int RANGE_MSB       = 1;

	// Implemented bit masks
	localparam logic [7:0] MASK_VOLTAGE_SET_SELECT_PIN      = 8'hFF;
	localparam logic [7:0] MASK_DISCHARGE = 8'h10;
	localparam logic [7:0] MASK_MODE      = 8'hC0;
	localparam logic [7:0] MASK_RANGE     = 8'h03;
	localparam logic [7:0] MASK_NONE      = 8'h00;

	// Reset values
	localparam logic [7:0] RST_VOLTAGE_SET_SELECT_PIN_HIGH  = 8'hFF;
	localparam logic [7:0] RST_VOLTAGE_SET_SELECT_PIN_LOW   = 8'hBF;
	localparam logic [7:0] RST_DISCHARGE  = 8'h10;
	localparam logic [7:0] RST_MODE       = 8'h00;

	// Register port request from the serial bus logic
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} bvc_reg_req_t;

	// Converter control outputs
	typedef struct packed {
		logic       enable;
		logic [6:0] code;
		logic [1:0] range;
		logic       forced_pwm;
		logic       discharge_path;
	} bvc_ctrl_t;

	// Whole state of the register bank
	typedef struct packed {
		logic [7:0] voltage_set_select_pin_high;
		logic [7:0] voltage_set_select_pin_low;
		logic [7:0] discharge;
		logic [7:0] mode;
		logic [7:0] range_high;
		logic [7:0] range_low;
		logic [7:0] rdata;
		logic       rvalid;
		bvc_ctrl_t  ctrl;
	} bvc_state_t;

endpackage : bvc_pkg

`default_nettype wire

//--- rtl/bvc_sync.sv
// Two-flop synchroniser for asynchronous pin inputs
`default_nettype none

module bvc_sync #(
	parameter int W = 2
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rstn,
	// Asynchronous input and synchronised output
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} bvc_sync_state_t;

	bvc_sync_state_t s;
	bvc_sync_state_t next_s;

	always_comb
	begin
		next_s    = s;
		next_s.s1 = d;
		next_s.s2 = s.s1;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			s <= '0;
		else
			s <= next_s;
	end

	assign q = s.s2;

endmodule : bvc_sync

`default_nettype wire

//--- rtl/bvc_regs.sv
// Control register bank of the step-down converter with voltage-set selection
`default_nettype none

module bvc_regs #(
	parameter logic [1:0] RANGE_HIGH_RST = 2'h0,
	parameter logic [1:0] RANGE_LOW_RST  = 2'h0
) (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              rstn,
	// Pins
	input  wire logic              enable_pin,
	input  wire logic              voltage_set_select_pin,
	// Register port
	input  wire bvc_pkg::bvc_reg_req_t reg_req,
	output logic      [7:0]        reg_rdata,
	output logic                   reg_rvalid,
	// Converter control
	output bvc_pkg::bvc_ctrl_t     ctrl
);

	// Implemented bits of a register; zero marks an unmapped offset
	function automatic logic [7:0] reg_mask(input logic [7:0] addr);
		case (addr)
			bvc_pkg::ADDR_VOLTAGE_SET_SELECT_PIN_HIGH:  reg_mask = bvc_pkg::MASK_VOLTAGE_SET_SELECT_PIN;
			bvc_pkg::ADDR_VOLTAGE_SET_SELECT_PIN_LOW:   reg_mask = bvc_pkg::MASK_VOLTAGE_SET_SELECT_PIN;
			bvc_pkg::ADDR_DISCHARGE:  reg_mask = bvc_pkg::MASK_DISCHARGE;
			bvc_pkg::ADDR_MODE:       reg_mask = bvc_pkg::MASK_MODE;
			bvc_pkg::ADDR_RANGE_HIGH: reg_mask = bvc_pkg::MASK_RANGE;
			bvc_pkg::ADDR_RANGE_LOW:  reg_mask = bvc_pkg::MASK_RANGE;
			default:                  reg_mask = bvc_pkg::MASK_NONE;
		endcase
	endfunction : reg_mask

	logic [1:0]          pins_sync;
	logic                en_s;
	logic                sel_high;
	logic [7:0]          wval;
	logic [7:0]          rval;
	logic [7:0]          sel_reg;
	logic [7:0]          sel_range;
	logic                next_enable;
	bvc_pkg::bvc_state_t s;
	bvc_pkg::bvc_state_t next_s;

	bvc_sync #(
		.W (2)
	) u_sync (
		.clk  (clk),
		.rstn (rstn),
		.d    ({enable_pin, voltage_set_select_pin}),
		.q    (pins_sync)
	);

	assign en_s     = pins_sync[1];
	assign sel_high = pins_sync[0];

	always_comb
	begin
		next_s = s;
		wval   = reg_req.wdata & reg_mask(reg_req.addr);
		// Register writes
		if (reg_req.wr)
		begin
			case (reg_req.addr)
				bvc_pkg::ADDR_VOLTAGE_SET_SELECT_PIN_HIGH:  next_s.voltage_set_select_pin_high  = wval;
				bvc_pkg::ADDR_VOLTAGE_SET_SELECT_PIN_LOW:   next_s.voltage_set_select_pin_low   = wval;
				bvc_pkg::ADDR_DISCHARGE:  next_s.discharge  = wval;
				bvc_pkg::ADDR_MODE:       next_s.mode       = wval;
				bvc_pkg::ADDR_RANGE_HIGH: next_s.range_high = wval;
				bvc_pkg::ADDR_RANGE_LOW:  next_s.range_low  = wval;
				default:                  next_s.mode       = s.mode;
			endcase
		end
		// Register reads return the value held before a same-cycle write
		case (reg_req.addr)
			bvc_pkg::ADDR_VOLTAGE_SET_SELECT_PIN_HIGH:  rval = s.voltage_set_select_pin_high;
			bvc_pkg::ADDR_VOLTAGE_SET_SELECT_PIN_LOW:   rval = s.voltage_set_select_pin_low;
			bvc_pkg::ADDR_DISCHARGE:  rval = s.discharge;
			bvc_pkg::ADDR_MODE:       rval = s.mode;
			bvc_pkg::ADDR_RANGE_HIGH: rval = s.range_high;
			bvc_pkg::ADDR_RANGE_LOW:  rval = s.range_low;
			default:                  rval = bvc_pkg::MASK_NONE;
		endcase
		next_s.rvalid = reg_req.rd;
		if (reg_req.rd)
			next_s.rdata = rval & reg_mask(reg_req.addr);
		// Voltage-set selection picks the active register set
		sel_reg   = sel_high ? s.voltage_set_select_pin_high : s.voltage_set_select_pin_low;
		sel_range = sel_high ? s.range_high : s.range_low;
		next_enable = en_s & sel_reg[bvc_pkg::ENABLE_GATE_BIT];
		next_s.ctrl.enable = next_enable;
		next_s.ctrl.code   = sel_reg[bvc_pkg::CODE_MSB:0];
		next_s.ctrl.range  = sel_range[bvc_pkg::RANGE_MSB:0];
		next_s.ctrl.forced_pwm = sel_high ? s.mode[bvc_pkg::PWM_HIGH_BIT]
		                                  : s.mode[bvc_pkg::PWM_LOW_BIT];
		next_s.ctrl.discharge_path = ~next_enable & s.discharge[bvc_pkg::DISCHARGE_BIT];
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			s            <= '0;
			s.voltage_set_select_pin_high  <= bvc_pkg::RST_VOLTAGE_SET_SELECT_PIN_HIGH;
			s.voltage_set_select_pin_low   <= bvc_pkg::RST_VOLTAGE_SET_SELECT_PIN_LOW;
			s.discharge  <= bvc_pkg::RST_DISCHARGE;
			s.mode       <= bvc_pkg::RST_MODE;
			s.range_high <= {6'h00, RANGE_HIGH_RST};
			s.range_low  <= {6'h00, RANGE_LOW_RST};
		end
		else
			s <= next_s;
	end

	assign reg_rdata  = s.rdata;
	assign reg_rvalid = s.rvalid;
	assign ctrl       = s.ctrl;

endmodule : bvc_regs

`default_nettype wire

//--- dv/bvc_asserts.sv
// Port checker for the converter control register bank
`default_nettype none
module bvc_asserts (
	// Clock, reset and pins
	input wire logic clk,
	input wire logic rstn,
	input wire logic enable_pin,
	input wire logic voltage_set_select_pin,
	// Register port and converter control
	input wire bvc_pkg::bvc_reg_req_t reg_req,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rvalid,
	input wire bvc_pkg::bvc_ctrl_t ctrl
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	sequence s_low_wr;
		(!voltage_set_select_pin)[*4] ##0 (reg_req.wr && reg_req.addr == 8'h11) ##1 !voltage_set_select_pin;
	endsequence
	sequence s_wr_rd;
		(reg_req.wr && reg_req.addr == 8'h11) ##2 (reg_req.rd && reg_req.addr == 8'h11);
	endsequence
	chk_rvalid_after_rd: assert property (reg_req.rd |=> reg_rvalid)
		else $error("read strobe gave no valid pulse");
	chk_rvalid_cause: assert property (reg_rvalid |-> $past(reg_req.rd))
		else $error("valid pulse without a read");
	chk_unmapped_zero: assert property (reg_req.rd && reg_req.addr == 8'h13 |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	chk_mode_reserved: assert property (reg_req.rd && reg_req.addr == 8'h14 |=> reg_rdata[5:0] == 6'h00)
		else $error("mode reserved bits not zero");
	chk_pin_gate: assert property ((!enable_pin)[*4] |-> !ctrl.enable)
		else $error("enabled while enable pin low");
	chk_discharge_off: assert property (ctrl.discharge_path |-> !ctrl.enable)
		else $error("discharge path while enabled");
	chk_code_low: assert property (s_low_wr |=> ctrl.code == $past(reg_req.wdata[6:0], 2))
		else $error("low set code not applied");
	chk_readback_low: assert property (s_wr_rd |=> reg_rdata == $past(reg_req.wdata, 3))
		else $error("low set readback wrong");
endmodule : bvc_asserts
`default_nettype wire

//--- dv/bvc_host.sv
// Host model driving the register port strobes
`default_nettype none
module bvc_host (
	// Clock and request
	input wire logic clk,
	output var bvc_pkg::bvc_reg_req_t reg_req
);
	timeunit 1ns;
	timeprecision 100ps;
	initial reg_req = '0;
	// Address and data go to the inverse once released
	task xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		#1 reg_req = '{w, !w, a, d};
		@(posedge clk);
		#1 reg_req = '{1'b0, 1'b0, ~a, ~d};
	endtask : xfer
endmodule : bvc_host
`default_nettype wire

//--- dv/bvc_regs_tb.sv
// Testbench for the converter control register bank
`default_nettype none
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin err_total++; $display("[FAIL] %s exp %h got %h", n, e, a); end end
module bvc_regs_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 0;
	logic rstn = 0;
	logic enable_pin = 0;
	logic voltage_set_select_pin = 0;
	bvc_pkg::bvc_reg_req_t reg_req;
	logic [7:0] reg_rdata;
	logic reg_rvalid;
	bvc_pkg::bvc_ctrl_t ctrl;
	int err_total = 0;
	int tests_run = 0;
	logic [31:0] seed = 32'h4D5A;
	logic [7:0] exp_q[$];
	logic [7:0] exp_v;
	logic [7:0] ra[6] = '{8'h10, 8'h11, 8'h12, 8'h14, 8'h1C, 8'h1D};
	logic [7:0] rv[6] = '{8'hFF, 8'hBF, 8'h10, 8'h00, 8'h00, 8'h00};
	logic [7:0] wa[4] = '{8'h12, 8'h14, 8'h13, 8'h1C};
	logic [7:0] wv[4] = '{8'h10, 8'hC0, 8'h00, 8'h03};
	always #2.5 clk = ~clk;
	bvc_regs bvc_regs_inst (.clk(clk), .rstn(rstn), .enable_pin(enable_pin),
		.voltage_set_select_pin(voltage_set_select_pin), .reg_req(reg_req),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .ctrl(ctrl));
	bvc_host bvc_host_inst (.clk(clk), .reg_req(reg_req));
	function logic [31:0] xorshift(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : xorshift
	task wr(input logic [7:0] a, input logic [7:0] d);
		bvc_host_inst.xfer(1'b1, a, d);
	endtask : wr
	task rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		bvc_host_inst.xfer(1'b0, a, 8'h00);
	endtask : rd
	task ck(input logic [11:0] e);
		repeat (4) @(posedge clk);
		#1;
		`CHK("ctrl", e, ctrl)
	endtask : ck
	task end_sim;
		if (exp_q.size() != 0) err_total++;
		$display("checks %0d errors %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_sim
	// Sample away from the launching edge so each valid pulse is seen once
	always @(negedge clk)
	begin
		if (reg_rvalid === 1'b1)
		begin
			if (exp_q.size() == 0)
				err_total++;
			else
			begin
				exp_v = exp_q.pop_front();
				`CHK("rdata", exp_v, reg_rdata)
			end
		end
	end
	initial
	begin
		#50000;
		err_total++;
		end_sim;
	end
	initial
	begin
		repeat (12) @(posedge clk);
		#1 rstn = 1;
		foreach (ra[i]) rd(ra[i], rv[i]);
		foreach (wa[i])
		begin
			wr(wa[i], 8'hFF);
			rd(wa[i], wv[i]);
		end
		repeat (8)
		begin
			seed = xorshift(seed);
			wr(8'h11, seed[7:0]);
			rd(8'h11, seed[7:0]);
		end
		enable_pin = 1;
		wr(8'h1D, 8'h02);
		wr(8'h11, 8'h85);
		ck({1'b1, 7'h05, 2'h2, 1'b1, 1'b0});
		wr(8'h11, 8'h05);
		ck({1'b0, 7'h05, 2'h2, 1'b1, 1'b1});
		wr(8'h14, 8'h40);
		ck({1'b0, 7'h05, 2'h2, 1'b0, 1'b1});
		wr(8'h10, 8'hA5);
		voltage_set_select_pin = 1;
		ck({1'b1, 7'h25, 2'h3, 1'b1, 1'b0});
		enable_pin = 0;
		ck({1'b0, 7'h25, 2'h3, 1'b1, 1'b1});
		repeat (4) @(posedge clk);
		end_sim;
	end
endmodule : bvc_regs_tb
bind bvc_regs bvc_asserts bvc_asserts_inst (.*);
`default_nettype wire
